// [core/datapath_pkg.sv]
// Purpose: Shared constants and types for the processor register datapath.
// Assumes: One 125 MHz clock, Wishbone register access with 32-bit data.
// Notes:   Register offsets are byte addresses of aligned words.
package datapath_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CMD  = 8'h00;
   localparam logic [7:0] REG_PC   = 8'h04;
   localparam logic [7:0] REG_AC   = 8'h08;
   localparam logic [7:0] REG_STAT = 8'h0C;
   localparam logic [7:0] REG_EXT  = 8'h10;
   localparam logic [7:0] REG_IR   = 8'h14;
   localparam logic [7:0] REG_DIO  = 8'h18;
   localparam logic [7:0] REG_ADDR = 8'h1C;
   localparam logic [7:0] REG_PTR1 = 8'h20;
   localparam logic [7:0] REG_PTR2 = 8'h24;
   localparam logic [7:0] REG_PTR3 = 8'h28;

   // ----------------------------------------------------------------
   // Status layout, reset values and arithmetic constants
   // ----------------------------------------------------------------
   localparam int unsigned ST_CY   = 7;
   localparam int unsigned ST_OV   = 6;
   localparam int unsigned ST_S2   = 5;
   localparam int unsigned ST_S1   = 4;
   localparam int unsigned ST_IE   = 3;
   localparam logic [7:0]  ST_WMSK = 8'hCF;
   localparam logic [7:0]  RST8    = 8'h00;
   localparam logic [15:0] RST16   = 16'h0000;
   localparam logic [7:0]  DISP_EXT = 8'h80;
   localparam logic [4:0]  BCD_LIM = 5'h09;
   localparam logic [4:0]  BCD_ADJ = 5'h06;
   localparam logic [11:0] PC_STEP = 12'h001;

   // ----------------------------------------------------------------
   // Commands, functions and states
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_NOP = 4'h0, OP_FETCH = 4'h1, OP_FETCH2 = 4'h2, OP_MEMRD = 4'h3,
      OP_MEMWR = 4'h4, OP_ALU = 4'h5, OP_SHIFT = 4'h6, OP_XPAL = 4'h7,
      OP_XPAH = 4'h8, OP_XPPC = 4'h9, OP_LDE = 4'hA, OP_XAE = 4'hB,
      OP_CSA = 4'hC, OP_CAS = 4'hD, OP_INTCHK = 4'hE
   } op_t;
   typedef enum logic [2:0] {
      F_OR = 3'h0, F_XOR = 3'h1, F_INC = 3'h2, F_DEC = 3'h3,
      F_ADD = 3'h4, F_CAD = 3'h5, F_DAD = 3'h6
   } alu_fn_t;
   typedef enum logic [2:0] {
      SH_SR = 3'h0, SH_SRL = 3'h1, SH_RR = 3'h2, SH_RRL = 3'h3, SH_SIO = 3'h4
   } sh_fn_t;
   typedef enum logic {ST_IDLE = 1'b0, ST_STRB = 1'b1} state_t;
   typedef struct packed {
      logic [2:0] func;
      logic [1:0] psel;
      op_t        op;
   } cmd_t;
   typedef struct packed {
      logic [7:0] res;
      logic       cy;
      logic       ov;
   } alu_res_t;
endpackage : datapath_pkg

// [core/cpu_register_datapath.sv]
// Purpose: Register datapath of an 8-bit processor, stepped by commands.
// Assumes: Inputs synchronous to clk_i; memory answers within one strobe.
// Notes:   Each bus cycle strobes for one clock and samples at its end.
// How it works
// - Opcode byte and optional second byte as immediate data or displacement.
// - Program counter steps by one right before each fetch.
// - The step touches only the low twelve bits, no carry upward.
// - Upper four counter bits start at zero, changed via pointer exchange.
// - Three sixteen-bit pointer registers, loadable, used as pointers or data.
// - Taken interrupt swaps counter with pointer three, preloaded one low.
// - Indexed displacement of minus 128 uses the extension register instead.
// - Each opcode fetch loads the hidden instruction register with the opcode.
// - Hidden data register holds every byte moved while a strobe is low.
// - Hidden address register holds the address of each bus cycle.
// - Unit does OR, XOR, increment, decrement, binary and packed BCD add.
// - Right shifts with, without link or serial input; rotates; exchanges.
// - Low or high pointer byte swaps with the working register.
// - Program counter swaps directly with any pointer register.
// - Extension copies into or swaps with the working register.
// - Status copy to working register leaves status untouched.
// - Working copy to status skips sense bits four and five.
// - Status bits zero to two drive latched user output pins.
// - With interrupts allowed, high first sense input branches to service.
// - Second sense input is status bit five only, never an interrupt.
// - Overflow bit set by binary and complement add, kept by decimal add.
// - Carry bit set from top bit of every add and feeds the next.
// - Carry bit acts as link in link shift and link rotate.
// - Reset zeroes every visible register; first fetch is from 0001.
`timescale 1ns/1ps
`default_nettype none
module cpu_register_datapath (
   input  wire logic        clk_i,          // 125 MHz clock.
   input  wire logic        rst_i,          // Synchronous reset, high.
   input  wire logic        wb_cyc_i,       // Wishbone cycle.
   input  wire logic        wb_stb_i,       // Wishbone strobe.
   input  wire logic        wb_we_i,        // Wishbone write.
   input  wire logic [7:0]  wb_adr_i,       // Byte address.
   input  wire logic [3:0]  wb_sel_i,       // Byte lanes.
   input  wire logic [31:0] wb_dat_i,       // Write data.
   output logic      [31:0] wb_dat_o,       // Read data.
   output logic             wb_ack_o,       // Acknowledge.
   output logic      [15:0] addr_o,         // Bus cycle address.
   input  wire logic [7:0]  db_i,           // Data bus in.
   output logic      [7:0]  db_o,           // Data bus out.
   output logic             db_oe_o,        // Data bus drive enable.
   output logic             read_strobe_n_o,  // Read strobe, low.
   output logic             write_strobe_n_o, // Write strobe, low.
   input  wire logic        sense_one_i,    // First sense input.
   input  wire logic        sense_two_i,    // Second sense input.
   input  wire logic        serial_in_i,    // Serial data in.
   output logic             serial_out_o,   // Serial data out.
   output logic      [2:0]  user_out_o,     // Latched user flags.
   output logic             irq_taken_o     // Interrupt branch pulse.
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [15:0]      pc_r, pc_nxt, addr_r, addr_nxt;
   logic [3:1][15:0] ptr_r, ptr_nxt;
   logic [7:0]       ac_r, ac_nxt, ext_r, ext_nxt, ir_r, ir_nxt;
   logic [7:0]       dio_r, dio_nxt, stat_r, stat_nxt;
   datapath_pkg::cmd_t   cmd_r, cmd_nxt;
   datapath_pkg::state_t state_r, state_nxt;
   logic rd_n_r, rd_n_nxt, wr_n_r, wr_n_nxt, oe_r, oe_nxt;
   logic sout_r, sout_nxt, irq_r, irq_nxt, ack_r;
   logic [31:0] rdat_r, rd_mux;
   datapath_pkg::alu_res_t alu;

   // Twelve-bit wrap step; the page bits ride along unchanged.
   function automatic logic [15:0] inc12(input logic [15:0] v);
      inc12 = {v[15:12], v[11:0] + datapath_pkg::PC_STEP};
   endfunction : inc12

   // Byte-lane merge for sixteen-bit registers.
   function automatic logic [15:0] m16(input logic [15:0] o,
                                       input logic [15:0] n,
                                       input logic [1:0]  s);
      m16 = {s[1] ? n[15:8] : o[15:8], s[0] ? n[7:0] : o[7:0]};
   endfunction : m16

   // Arithmetic unit; decimal digits correct by six above nine.
   function automatic datapath_pkg::alu_res_t alu_f(input logic [2:0] fn,
      input logic [7:0] a, input logic [7:0] b, input logic ci);
      logic [8:0] s;
      logic [7:0] bb;
      logic [4:0] lo, hi;
      s = 9'h000;
      lo = 5'h00;
      hi = 5'h00;
      bb = (fn == datapath_pkg::F_CAD) ? ~b : b;
      alu_f = '{res: a, cy: ci, ov: 1'b0};
      case (fn)
         datapath_pkg::F_OR:  alu_f.res = a | b;
         datapath_pkg::F_XOR: alu_f.res = a ^ b;
         datapath_pkg::F_INC: alu_f.res = a + 8'h01;
         datapath_pkg::F_DEC: alu_f.res = a - 8'h01;
         datapath_pkg::F_ADD, datapath_pkg::F_CAD: begin
            s = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
            alu_f.res = s[7:0];
            alu_f.cy = s[8];
            alu_f.ov = (a[7] == bb[7]) && (s[7] != a[7]);
         end
         datapath_pkg::F_DAD: begin
            lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
            if (lo > datapath_pkg::BCD_LIM) lo = lo + datapath_pkg::BCD_ADJ;
            hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
            if (hi > datapath_pkg::BCD_LIM) hi = hi + datapath_pkg::BCD_ADJ;
            alu_f.res = {hi[3:0], lo[3:0]};
            alu_f.cy = hi[4];
         end
         default: alu_f.res = a;
      endcase
   endfunction : alu_f

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   // Commands start only when idle; a command written mid-cycle is dropped.
   wire         wb_req   = wb_cyc_i & wb_stb_i & ~ack_r;
   wire         wr_hit   = wb_req & wb_we_i;
   wire         idle     = (state_r == datapath_pkg::ST_IDLE);
   wire         start    = wr_hit & idle & (wb_adr_i == datapath_pkg::REG_CMD);
   wire datapath_pkg::cmd_t cmd_in = datapath_pkg::cmd_t'(wb_dat_i[8:0]);
   wire [1:0]   psel     = cmd_in.psel;
   wire [15:0]  base     = (psel == 2'b00) ? pc_r : ptr_r[psel];
   wire [7:0]   disp     = ((psel != 2'b00) && (dio_r == datapath_pkg::DISP_EXT))
                           ? ext_r : dio_r;
   wire [15:0]  ea       = base + {{8{disp[7]}}, disp};
   wire [7:0]   stat_view = {stat_r[7:6], sense_two_i, sense_one_i, stat_r[3:0]};
   wire [7:0]   opnd     = psel[0] ? ext_r : dio_r;
   wire         irq_go   = stat_r[datapath_pkg::ST_IE] & sense_one_i;

   assign alu = alu_f(cmd_in.func, ac_r, opnd, stat_r[datapath_pkg::ST_CY]);

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   // One command per idle cycle; bus commands hold the strobe one clock.
   always_comb begin
      pc_nxt = pc_r;
      ptr_nxt = ptr_r;
      ac_nxt = ac_r;
      ext_nxt = ext_r;
      ir_nxt = ir_r;
      dio_nxt = dio_r;
      addr_nxt = addr_r;
      stat_nxt = stat_r;
      cmd_nxt = cmd_r;
      state_nxt = state_r;
      rd_n_nxt = 1'b1;
      wr_n_nxt = 1'b1;
      oe_nxt = 1'b0;
      sout_nxt = sout_r;
      irq_nxt = 1'b0;
      case (state_r)
         datapath_pkg::ST_IDLE: begin
            if (start) begin
               cmd_nxt = cmd_in;
               case (cmd_in.op)
                  datapath_pkg::OP_FETCH, datapath_pkg::OP_FETCH2: begin
                     pc_nxt = inc12(pc_r);
                     addr_nxt = inc12(pc_r);
                     rd_n_nxt = 1'b0;
                     state_nxt = datapath_pkg::ST_STRB;
                  end
                  datapath_pkg::OP_MEMRD: begin
                     addr_nxt = ea;
                     rd_n_nxt = 1'b0;
                     state_nxt = datapath_pkg::ST_STRB;
                  end
                  datapath_pkg::OP_MEMWR: begin
                     addr_nxt = ea;
                     dio_nxt = ac_r;
                     wr_n_nxt = 1'b0;
                     oe_nxt = 1'b1;
                     state_nxt = datapath_pkg::ST_STRB;
                  end
                  datapath_pkg::OP_ALU: begin
                     ac_nxt = alu.res;
                     if (cmd_in.func >= datapath_pkg::F_ADD)
                        stat_nxt[datapath_pkg::ST_CY] = alu.cy;
                     if (cmd_in.func == datapath_pkg::F_ADD || cmd_in.func == datapath_pkg::F_CAD)
                        stat_nxt[datapath_pkg::ST_OV] = alu.ov;
                  end
                  datapath_pkg::OP_SHIFT: begin
                     case (cmd_in.func)
                        datapath_pkg::SH_SR:  ac_nxt = {1'b0, ac_r[7:1]};
                        datapath_pkg::SH_SRL: ac_nxt = {stat_r[datapath_pkg::ST_CY], ac_r[7:1]};
                        datapath_pkg::SH_RR:  ac_nxt = {ac_r[0], ac_r[7:1]};
                        datapath_pkg::SH_RRL: begin
                           ac_nxt = {stat_r[datapath_pkg::ST_CY], ac_r[7:1]};
                           stat_nxt[datapath_pkg::ST_CY] = ac_r[0];
                        end
                        datapath_pkg::SH_SIO: begin
                           ext_nxt = {serial_in_i, ext_r[7:1]};
                           sout_nxt = ext_r[0];
                        end
                        default: ac_nxt = ac_r;
                     endcase
                  end
                  datapath_pkg::OP_XPAL, datapath_pkg::OP_XPAH: begin
                     // Pointer zero is the counter itself.
                     ac_nxt = (cmd_in.op == datapath_pkg::OP_XPAL) ? base[7:0] : base[15:8];
                     if (psel == 2'b00)
                        pc_nxt = m16(pc_r, {ac_r, ac_r}, {cmd_in.op == datapath_pkg::OP_XPAH,
                                 cmd_in.op == datapath_pkg::OP_XPAL});
                     else
                        ptr_nxt[psel] = m16(base, {ac_r, ac_r}, {cmd_in.op == datapath_pkg::OP_XPAH,
                                        cmd_in.op == datapath_pkg::OP_XPAL});
                  end
                  datapath_pkg::OP_XPPC: begin
                     if (psel != 2'b00) begin
                        pc_nxt = ptr_r[psel];
                        ptr_nxt[psel] = pc_r;
                     end
                  end
                  datapath_pkg::OP_LDE: ac_nxt = ext_r;
                  datapath_pkg::OP_XAE: begin
                     ac_nxt = ext_r;
                     ext_nxt = ac_r;
                  end
                  datapath_pkg::OP_CSA: ac_nxt = stat_view;
                  datapath_pkg::OP_CAS: stat_nxt = ac_r & datapath_pkg::ST_WMSK;
                  datapath_pkg::OP_INTCHK: begin
                     // Only the first sense input can branch.
                     if (irq_go) begin
                        pc_nxt = ptr_r[3];
                        ptr_nxt[3] = pc_r;
                        stat_nxt[datapath_pkg::ST_IE] = 1'b0;
                        irq_nxt = 1'b1;
                     end
                  end
                  default: cmd_nxt = cmd_in;
               endcase
            end else if (wr_hit) begin
               // Software loads; pointers are plain storage as well.
               if (wb_adr_i == datapath_pkg::REG_PC)
                  pc_nxt = m16(pc_r, wb_dat_i[15:0], wb_sel_i[1:0]);
               else if (wb_adr_i == datapath_pkg::REG_AC && wb_sel_i[0])
                  ac_nxt = wb_dat_i[7:0];
               else if (wb_adr_i == datapath_pkg::REG_STAT && wb_sel_i[0])
                  stat_nxt = wb_dat_i[7:0] & datapath_pkg::ST_WMSK;
               else if (wb_adr_i == datapath_pkg::REG_EXT && wb_sel_i[0])
                  ext_nxt = wb_dat_i[7:0];
               else if (wb_adr_i == datapath_pkg::REG_PTR1)
                  ptr_nxt[1] = m16(ptr_r[1], wb_dat_i[15:0], wb_sel_i[1:0]);
               else if (wb_adr_i == datapath_pkg::REG_PTR2)
                  ptr_nxt[2] = m16(ptr_r[2], wb_dat_i[15:0], wb_sel_i[1:0]);
               else if (wb_adr_i == datapath_pkg::REG_PTR3)
                  ptr_nxt[3] = m16(ptr_r[3], wb_dat_i[15:0], wb_sel_i[1:0]);
            end
         end
         datapath_pkg::ST_STRB: begin
            state_nxt = datapath_pkg::ST_IDLE;
            if (!rd_n_r) begin
               dio_nxt = db_i;
               if (cmd_r.op == datapath_pkg::OP_FETCH)
                  ir_nxt = db_i;
               if (cmd_r.op == datapath_pkg::OP_MEMRD)
                  ac_nxt = db_i;
            end
         end
         default: state_nxt = datapath_pkg::ST_IDLE;
      endcase
   end

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   // Unmapped addresses still acknowledge and read as zero.
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (wb_adr_i == datapath_pkg::REG_CMD)       rd_mux = {31'h0, ~idle};
      else if (wb_adr_i == datapath_pkg::REG_PC)   rd_mux = {16'h0000, pc_r};
      else if (wb_adr_i == datapath_pkg::REG_AC)   rd_mux = {24'h00_0000, ac_r};
      else if (wb_adr_i == datapath_pkg::REG_STAT) rd_mux = {24'h00_0000, stat_view};
      else if (wb_adr_i == datapath_pkg::REG_EXT)  rd_mux = {24'h00_0000, ext_r};
      else if (wb_adr_i == datapath_pkg::REG_IR)   rd_mux = {24'h00_0000, ir_r};
      else if (wb_adr_i == datapath_pkg::REG_DIO)  rd_mux = {24'h00_0000, dio_r};
      else if (wb_adr_i == datapath_pkg::REG_ADDR) rd_mux = {16'h0000, addr_r};
      else if (wb_adr_i == datapath_pkg::REG_PTR1) rd_mux = {16'h0000, ptr_r[1]};
      else if (wb_adr_i == datapath_pkg::REG_PTR2) rd_mux = {16'h0000, ptr_r[2]};
      else if (wb_adr_i == datapath_pkg::REG_PTR3) rd_mux = {16'h0000, ptr_r[3]};
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Reset clears every visible register, so the first fetch is 0001.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pc_r <= datapath_pkg::RST16;
         ptr_r <= {3{datapath_pkg::RST16}};
         ac_r <= datapath_pkg::RST8;
         ext_r <= datapath_pkg::RST8;
         stat_r <= datapath_pkg::RST8;
      end else begin
         pc_r <= pc_nxt;
         ptr_r <= ptr_nxt;
         ac_r <= ac_nxt;
         ext_r <= ext_nxt;
         stat_r <= stat_nxt;
      end
   end

   // Hidden registers, bus strobes and the slave answer.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ir_r <= datapath_pkg::RST8;
         dio_r <= datapath_pkg::RST8;
         addr_r <= datapath_pkg::RST16;
         cmd_r <= datapath_pkg::cmd_t'(9'h000);
         state_r <= datapath_pkg::ST_IDLE;
         {rd_n_r, wr_n_r, oe_r} <= 3'b110;
         {sout_r, irq_r, ack_r} <= 3'b000;
         rdat_r <= 32'h0000_0000;
      end else begin
         ir_r <= ir_nxt;
         dio_r <= dio_nxt;
         addr_r <= addr_nxt;
         cmd_r <= cmd_nxt;
         state_r <= state_nxt;
         {rd_n_r, wr_n_r, oe_r} <= {rd_n_nxt, wr_n_nxt, oe_nxt};
         {sout_r, irq_r} <= {sout_nxt, irq_nxt};
         ack_r <= wb_req;
         rdat_r <= wb_req ? rd_mux : rdat_r;
      end
   end

   assign wb_dat_o = rdat_r;
   assign wb_ack_o = ack_r;
   assign addr_o = addr_r;
   assign db_o = dio_r;
   assign db_oe_o = oe_r;
   assign read_strobe_n_o = rd_n_r;
   assign write_strobe_n_o = wr_n_r;
   assign serial_out_o = sout_r;
   assign user_out_o = stat_r[2:0];
   assign irq_taken_o = irq_r;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   wire st_fetch = start & (cmd_in.op == datapath_pkg::OP_FETCH);
   wire st_cas = start & (cmd_in.op == datapath_pkg::OP_CAS);
   wire st_dad = start & (cmd_in.op == datapath_pkg::OP_ALU) & (cmd_in.func == datapath_pkg::F_DAD);
   wire st_int = start & (cmd_in.op == datapath_pkg::OP_INTCHK);
   wire st_bus = start & (cmd_in.op >= datapath_pkg::OP_FETCH) & (cmd_in.op <= datapath_pkg::OP_MEMWR);
   wire wr_stat = wr_hit & idle & (wb_adr_i == datapath_pkg::REG_STAT);

   sequence s_rd_cycle;
      !read_strobe_n_o ##1 read_strobe_n_o;
   endsequence

   property p_pc_page;
      @(posedge clk_i) disable iff (rst_i) st_fetch |=> pc_r[15:12] == $past(pc_r[15:12]);
   endproperty
   a_pc_page: assert property (p_pc_page) else $error("page bits moved on fetch");
   property p_pc_step;
      @(posedge clk_i) disable iff (rst_i)
         st_fetch |=> (pc_r[11:0] == $past(pc_r[11:0]) + 12'h001) && addr_o == pc_r;
   endproperty
   a_pc_step: assert property (p_pc_step) else $error("fetch did not step counter");
   property p_strobe;
      @(posedge clk_i) disable iff (rst_i) $fell(read_strobe_n_o) |-> s_rd_cycle ##0 dio_r == $past(db_i);
   endproperty
   a_strobe: assert property (p_strobe) else $error("read byte not held");
   property p_ir;
      @(posedge clk_i) disable iff (rst_i) st_fetch |=> s_rd_cycle ##0 ir_r == $past(db_i);
   endproperty
   a_ir: assert property (p_ir) else $error("opcode not loaded");
   property p_addr;
      @(posedge clk_i) disable iff (rst_i) st_bus |=> ##1 $stable(addr_o);
   endproperty
   a_addr: assert property (p_addr) else $error("address moved in cycle");
   property p_cas;
      @(posedge clk_i) disable iff (rst_i)
         st_cas |=> stat_r == ($past(ac_r) & 8'hCF) && ac_r == $past(ac_r);
   endproperty
   a_cas: assert property (p_cas) else $error("status copy wrong");
   property p_dad_ov;
      @(posedge clk_i) disable iff (rst_i) st_dad |=> $stable(stat_r[6]);
   endproperty
   a_dad_ov: assert property (p_dad_ov) else $error("decimal add changed overflow");
   property p_no_irq;
      @(posedge clk_i) disable iff (rst_i) st_int && !irq_go |=> $stable(pc_r) && !irq_taken_o;
   endproperty
   a_no_irq: assert property (p_no_irq) else $error("branch without allowed request");
   property p_uout;
      @(posedge clk_i) disable iff (rst_i) !st_cas && !wr_stat |=> $stable(user_out_o);
   endproperty
   a_uout: assert property (p_uout) else $error("user flags changed unasked");
endmodule : cpu_register_datapath
`default_nettype wire

// [dv/ext_mem.sv]
// Purpose: Memory behind the processor data bus.
// Assumes: One strobe cycle per byte.
// Notes:   Released bus shows the inverse of the last byte.
`timescale 1ns/1ps
`default_nettype none
module ext_mem (
   input  wire logic        clk_i,   // Clock.
   input  wire logic [15:0] addr_i,  // Cycle address.
   input  wire logic        rd_n_i,  // Read strobe, low.
   input  wire logic        wr_n_i,  // Write strobe, low.
   input  wire logic        oe_i,    // Processor drives bus.
   input  wire logic [7:0]  wd_i,    // Processor data.
   output logic      [7:0]  rd_o     // Data to processor.
);
   logic [7:0] mem [0:255];
   logic [7:0] last_r;
   // An idle bus must not look like valid data, so it shows a changed value.
   assign rd_o = rd_n_i ? ~last_r : mem[addr_i[7:0]];
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;
      last_r = 8'h00;
   end
   // Plain always, because the initial block also fills this storage.
   always @(posedge clk_i) begin
      if (!rd_n_i) last_r <= rd_o;
      if (!wr_n_i && oe_i) mem[addr_i[7:0]] <= wd_i;
   end
endmodule : ext_mem
`default_nettype wire

// [dv/cpu_register_datapath_tb_top.sv]
// Purpose: Self-checking bench for the register datapath.
// Assumes: Wishbone ack arrives one cycle after a request is taken.
// Notes:   Random add operands come from a fixed seed.
`timescale 1ns/1ps
`default_nettype none
module cpu_register_datapath_tb_top;
   logic clk_i, rst_i, cyc, stb, we, rn, wn, oe, s1, s2, sin, so, irq, ack;
   logic [7:0]  adr, dbi, dbo, a, b;
   logic [31:0] dat, q, rdo;
   logic [15:0] ao;
   logic [2:0]  uo;
   logic [8:0]  sum;
   int n_errors, n_compared, n_irq;
   cpu_register_datapath dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdo), .wb_ack_o(ack), .addr_o(ao),
      .db_i(dbi), .db_o(dbo), .db_oe_o(oe), .read_strobe_n_o(rn), .write_strobe_n_o(wn),
      .sense_one_i(s1), .sense_two_i(s2), .serial_in_i(sin), .serial_out_o(so), .user_out_o(uo),
      .irq_taken_o(irq));
   ext_mem mem (.clk_i(clk_i), .addr_i(ao), .rd_n_i(rn), .wr_n_i(wn), .oe_i(oe), .wd_i(dbo), .rd_o(dbi));
   // Count branch pulses, so a stray or a missing one shows at the end.
   always @(posedge clk_i) if (irq === 1'b1) n_irq++;
   // One classic Wishbone cycle; the request stands until ack is sampled.
   task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= ad; dat <= d;
      do @(posedge clk_i); while (ack !== 1'b1 && ++n < 50);
      if (n >= 50) n_errors++;
      q = rdo;
      cyc <= 1'b0; stb <= 1'b0;
   endtask : wb
   task automatic chk(input string nm, input logic [31:0] ad, input logic [31:0] e);
      wb(1'b0, ad[7:0], 32'h0);
      n_compared++;
      if (q !== e) begin n_errors++; $display("BAD %s exp %h got %h", nm, e, q); end
   endtask : chk
   function automatic logic [31:0] cmd(input logic [2:0] f, input logic [1:0] p, input logic [3:0] o);
      return {23'h0, f, p, o};
   endfunction : cmd
   task final_report;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : final_report
   initial begin clk_i = 1'b0; forever #4 clk_i = ~clk_i; end
   initial begin #400000; n_errors++; final_report(); end
   // Main sequence: reset, fetches, random adds, status copy, interrupt.
   initial begin
      rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; dat = 32'h0; s1 = 1'b0; s2 = 1'b0;
      sin = 1'b0;
      void'($urandom(32'h6992));
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      chk("pc", datapath_pkg::REG_PC, 32'h0);
      wb(1'b1, datapath_pkg::REG_CMD, cmd(3'h0, 2'h0, datapath_pkg::OP_FETCH));
      chk("pc", datapath_pkg::REG_PC, 32'h1);
      chk("addr", datapath_pkg::REG_ADDR, 32'h1);
      chk("ir", datapath_pkg::REG_IR, {24'h0, 8'h01 ^ 8'hA5});
      wb(1'b1, datapath_pkg::REG_PC, 32'h1FFF);
      wb(1'b1, datapath_pkg::REG_CMD, cmd(3'h0, 2'h0, datapath_pkg::OP_FETCH));
      chk("pc", datapath_pkg::REG_PC, 32'h1000);
      repeat (4) begin
         a = 8'($urandom); b = 8'($urandom); sum = a + b;
         wb(1'b1, datapath_pkg::REG_AC, {24'h0, a});
         wb(1'b1, datapath_pkg::REG_EXT, {24'h0, b});
         wb(1'b1, datapath_pkg::REG_STAT, 32'h0);
         wb(1'b1, datapath_pkg::REG_CMD, cmd(datapath_pkg::F_ADD, 2'h1, datapath_pkg::OP_ALU));
         chk("ac", datapath_pkg::REG_AC, {24'h0, sum[7:0]});
         chk("stat", datapath_pkg::REG_STAT, {24'h0, sum[8], (a[7] == b[7]) && (sum[7] != a[7]), 6'h0});
      end
      // Decimal corner: 58 + 47 gives 05 with carry, overflow preset and kept.
      wb(1'b1, datapath_pkg::REG_AC, 32'h58);
      wb(1'b1, datapath_pkg::REG_EXT, 32'h47);
      wb(1'b1, datapath_pkg::REG_STAT, 32'h40);
      wb(1'b1, datapath_pkg::REG_CMD, cmd(datapath_pkg::F_DAD, 2'h1, datapath_pkg::OP_ALU));
      chk("ac", datapath_pkg::REG_AC, 32'h05);
      chk("stat", datapath_pkg::REG_STAT, 32'hC0);
      // Serial shift: a one enters at the top, the old low bit leaves.
      sin <= 1'b1;
      wb(1'b1, datapath_pkg::REG_CMD, cmd(datapath_pkg::SH_SIO, 2'h0, datapath_pkg::OP_SHIFT));
      chk("ext", datapath_pkg::REG_EXT, 32'hA3);
      n_compared++; if (so !== 1'b1) begin n_errors++; $display("BAD serial_out exp 1 got %h", so); end
      wb(1'b1, datapath_pkg::REG_AC, 32'hFF);
      wb(1'b1, datapath_pkg::REG_CMD, cmd(3'h0, 2'h0, datapath_pkg::OP_CAS));
      chk("stat", datapath_pkg::REG_STAT, 32'hCF);
      n_compared++; if (uo !== 3'h7) begin n_errors++; $display("BAD user_out exp 7 got %h", uo); end
      // Second sense input is visible but never branches, even with interrupts allowed.
      s2 <= 1'b1;
      chk("stat", datapath_pkg::REG_STAT, 32'hEF);
      wb(1'b1, datapath_pkg::REG_CMD, cmd(3'h0, 2'h0, datapath_pkg::OP_CSA));
      chk("ac", datapath_pkg::REG_AC, 32'hEF);
      wb(1'b1, datapath_pkg::REG_CMD, cmd(3'h0, 2'h0, datapath_pkg::OP_INTCHK));
      chk("pc", datapath_pkg::REG_PC, 32'h1000);
      wb(1'b1, datapath_pkg::REG_PTR3, 32'h0123);
      s1 <= 1'b1;
      wb(1'b1, datapath_pkg::REG_CMD, cmd(3'h0, 2'h0, datapath_pkg::OP_INTCHK));
      chk("pc", datapath_pkg::REG_PC, 32'h0123);
      chk("ptr3", datapath_pkg::REG_PTR3, 32'h1000);
      n_compared++; if (n_irq !== 1) begin n_errors++; $display("BAD irq_taken exp 1 got %0d", n_irq); end
      final_report();
   end
endmodule : cpu_register_datapath_tb_top
`default_nettype wire
